// ==== logic/sdap_pkg.sv ====
// Constants, types and helpers for the short data address packet encoder
package sdap_pkg;

	localparam int          ADDR_W        = 64;
	localparam int          HIST_N        = 3;
	localparam logic [1:0]  WORD_LOW      = 2'h0;
	localparam logic [1:0]  HALF_LOW      = 2'h2;
	localparam logic [1:0]  HDR_SHORT_TAG = 2'h2;
	localparam logic [5:0]  HDR_BYTE_TAG  = 6'h05;
	localparam logic [3:0]  HDR_HALF_TAG  = 4'h6;
	localparam logic [1:0]  SEL_STEP2     = 2'h3;
	localparam logic [63:0] HIST_RESET    = 64'h0000_0000_0000_0000;
	localparam int          FIFO_DEPTH    = 8;
	localparam int          FIFO_WIDTH    = 8;
	localparam int          LSB_HALF      = 4;
	localparam int          LSB_SHORT     = 6;
	localparam int          LSB_BYTE      = 10;
	localparam int          RDY_SLACK     = 3;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b01,
		ST_PAYLOAD = 2'b10
	} enc_state_e;

	// Bits from lsb upward of two addresses agree
	function automatic logic above_match(input logic [63:0] a,
		input logic [63:0] b, input int lsb);
		above_match = ((a ^ b) >> lsb) == 64'h0000_0000_0000_0000;
	endfunction : above_match

	// {usable, select code} from per-entry matches and the +2 request
	function automatic logic [2:0] pick_select(input logic [2:0] m,
		input logic step2);
		if (step2) begin
			pick_select = {m[0], SEL_STEP2};
		end else if (m[0]) begin
			pick_select = 3'h4;
		end else if (m[1]) begin
			pick_select = 3'h5;
		end else begin
			pick_select = {m[2], 2'h2};
		end
	endfunction : pick_select

	// History entry named by a select code
	function automatic logic [1:0] select_entry(input logic [1:0] code);
		select_entry = (code == SEL_STEP2) ? 2'h0 : code;
	endfunction : select_entry

endpackage : sdap_pkg

// ==== logic/sdap_fifo.sv ====
// Byte FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module sdap_fifo
	import sdap_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic [$clog2(DEPTH+1)-1:0] o_level,
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	localparam bit POW2 = (DEPTH & (DEPTH - 1)) == 0;

	if (DEPTH < 4 || !POW2 || WIDTH < 1) begin : g_bad_cfg
		$error("sdap_fifo: DEPTH must be a power of two >= 4");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             ov_q;
	logic [WIDTH-1:0] od_q;

	wire push = i_in_valid && o_in_ready;
	wire load = (cnt_q != '0) && (!ov_q || i_out_ready);
	wire drop = ov_q && i_out_ready && !load;

	assign o_in_ready  = cnt_q != CW'(DEPTH);
	assign o_level     = cnt_q;
	assign o_out_valid = ov_q;
	assign o_out_data  = od_q;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
			ov_q  <= 1'b0;
			od_q  <= '0;
		end else begin
			wr_q  <= push ? wr_q + AW'(1) : wr_q;
			rd_q  <= load ? rd_q + AW'(1) : rd_q;
			cnt_q <= cnt_q + CW'(push) - CW'(load);
			ov_q  <= load ? 1'b1 : (drop ? 1'b0 : ov_q);
			od_q  <= load ? mem_q[rd_q] : od_q;
		end
	end
endmodule : sdap_fifo
`default_nettype wire

// ==== logic/short_data_address_packet_codec.sv ====
// Short data address packet encoder with address history and keys
`timescale 1ns/1ps
`default_nettype none
module short_data_address_packet_codec
	import sdap_pkg::*;
#(
	parameter int LKEY_W   = 8,
	parameter int RKEY_W   = 8,
	parameter int RKEY_MAX = 256,
	parameter int INDEX_W  = 4
) (
	input  wire logic              I_CLOCK,
	input  wire logic              I_RSTN,
	input  wire logic              I_XFER_VALID,
	input  wire logic [63:0]       I_XFER_ADDR,
	input  wire logic              I_XFER_STEP2,
	output logic                   O_XFER_READY,
	output logic                   O_XFER_REJECT,
	input  wire logic              I_ENDIAN_LOAD,
	input  wire logic              I_ENDIAN_BIG,
	output logic                   O_BYTE_VALID,
	output logic [7:0]             O_BYTE_DATA,
	input  wire logic              I_BYTE_READY,
	output logic                   O_ELEM_VALID,
	output logic [63:0]            O_ELEM_ADDR,
	output logic                   O_ELEM_BIG,
	output logic [LKEY_W-1:0]      O_ELEM_LEFT_KEY,
	output logic [RKEY_W-1:0]      O_ELEM_RIGHT_KEY,
	output logic [INDEX_W-1:0]     O_ELEM_INDEX
);
	localparam int LW = $clog2(FIFO_DEPTH+1);

	// Right key counter must hold every key below the wrap count
	if (RKEY_MAX < 2 || RKEY_MAX > (1 << RKEY_W)) begin : g_bad_rkey
		$error("codec: RKEY_MAX must be 2..2**RKEY_W");
	end
	// Left key needs room for the +2 step
	if (LKEY_W < 2) begin : g_bad_lkey
		$error("codec: LKEY_W must be at least 2");
	end
	if (INDEX_W < 1) begin : g_bad_index
		$error("codec: INDEX_W must be at least 1");
	end
	// Header and payload must both fit above the ready threshold
	if (FIFO_DEPTH <= RDY_SLACK) begin : g_bad_depth
		$error("codec: FIFO_DEPTH too small for ready slack");
	end

	enc_state_e        st_q;
	enc_state_e        st_d;
	logic [63:0]       hist_q [HIST_N];
	logic [LKEY_W-1:0] lkey_q;
	logic [RKEY_W-1:0] rkey_q;
	logic              big_q;
	logic [7:0]        pay_q;
	logic              rdy_q;
	logic              rej_q;
	logic              ev_q;
	logic [63:0]       ea_q;
	logic              eb_q;
	logic [LKEY_W-1:0] el_q;
	logic [INDEX_W-1:0] ei_q;

	logic              f_ready;
	logic [LW-1:0]     f_level;

	// Per-entry matches above each form's carried bits
	logic [2:0] m4;
	logic [2:0] m6;
	logic [2:0] m10;
	always_comb begin
		for (int i = 0; i < HIST_N; i++) begin
			m4[i]  = above_match(hist_q[i], I_XFER_ADDR, LSB_HALF);
			m6[i]  = above_match(hist_q[i], I_XFER_ADDR, LSB_SHORT);
			m10[i] = above_match(hist_q[i], I_XFER_ADDR, LSB_BYTE);
		end
	end

	wire       is_half = I_XFER_ADDR[1:0] == HALF_LOW;
	wire       is_word = I_XFER_ADDR[1:0] == WORD_LOW;
	wire [2:0] p4      = pick_select(m4, I_XFER_STEP2);
	wire [2:0] p6      = pick_select(m6, I_XFER_STEP2);
	wire [2:0] p10     = pick_select(m10, I_XFER_STEP2);
	wire       use_hw  = is_half && p4[2];
	wire       use_w4  = is_word && p6[2];
	wire       use_w8  = is_word && !p6[2] && p10[2];
	wire       can_enc = use_hw || use_w4 || use_w8;
	wire [1:0] sel     = use_hw ? p4[1:0] : (use_w4 ? p6[1:0] : p10[1:0]);
	wire [1:0] entry   = select_entry(sel);
	wire [63:0] base   = hist_q[entry];

	// Address as the analyzer rebuilds it from the selected entry
	wire [63:0] addr_hw = {base[63:4], I_XFER_ADDR[3:2], HALF_LOW};
	wire [63:0] addr_w4 = {base[63:6], I_XFER_ADDR[5:2], WORD_LOW};
	wire [63:0] addr_w8 = {base[63:10], I_XFER_ADDR[9:2], WORD_LOW};
	wire [63:0] rebuilt = use_hw ? addr_hw : (use_w4 ? addr_w4 : addr_w8);

	// Header bytes for each form
	wire [7:0] hdr_hw = {HDR_HALF_TAG, I_XFER_ADDR[3:2], sel};
	wire [7:0] hdr_w4 = {HDR_SHORT_TAG, I_XFER_ADDR[5:2], sel};
	wire [7:0] hdr_w8 = {HDR_BYTE_TAG, sel};
	wire [7:0] header = use_hw ? hdr_hw : (use_w4 ? hdr_w4 : hdr_w8);

	wire take    = I_XFER_VALID && rdy_q && f_ready && (st_q == ST_IDLE);
	wire accept  = take && can_enc;
	wire reject  = take && !can_enc;
	wire pay_put = (st_q == ST_PAYLOAD) && f_ready;
	wire f_push  = accept || pay_put;
	wire [7:0] f_data = (st_q == ST_PAYLOAD) ? pay_q : header;

	wire              step2_sel = sel == SEL_STEP2;
	wire [LKEY_W-1:0] lkey_inc  = step2_sel ? LKEY_W'(2) : LKEY_W'(1);
	wire [LKEY_W-1:0] lkey_d    = lkey_q + lkey_inc;
	wire              rkey_wrap = rkey_q == RKEY_W'(RKEY_MAX - 1);
	wire [RKEY_W-1:0] rkey_d    = rkey_wrap ? '0 : rkey_q + RKEY_W'(1);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (accept && use_w8) begin
					st_d = ST_PAYLOAD;
				end
			end
			ST_PAYLOAD: begin
				if (pay_put) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Leave room for a header and its payload byte
	wire rdy_d = (st_d == ST_IDLE) &&
		(f_level <= LW'(FIFO_DEPTH - RDY_SLACK));

	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			st_q  <= ST_IDLE;
			rdy_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			rdy_q <= rdy_d;
			rej_q <= reject;
		end
	end

	// Payload byte of the eight-bit form, pushed one cycle after its header
	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pay_q <= 8'h00;
		end else begin
			pay_q <= accept ? I_XFER_ADDR[9:2] : pay_q;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			for (int i = 0; i < HIST_N; i++) begin
				hist_q[i] <= HIST_RESET;
			end
		end else if (accept) begin
			hist_q[entry] <= rebuilt;
		end
	end

	// Stored endianness for elements that carry none of their own
	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			lkey_q <= '0;
			rkey_q <= '0;
			big_q  <= 1'b0;
		end else begin
			lkey_q <= accept ? lkey_d : lkey_q;
			rkey_q <= accept ? rkey_d : rkey_q;
			big_q  <= I_ENDIAN_LOAD ? I_ENDIAN_BIG : big_q;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ev_q <= 1'b0;
		end else begin
			ev_q <= accept;
		end
	end

	// Element fields stand until the next accepted packet
	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ea_q <= HIST_RESET;
			eb_q <= 1'b0;
			el_q <= '0;
			ei_q <= '0;
		end else if (accept) begin
			ea_q <= rebuilt;
			eb_q <= big_q;
			el_q <= lkey_d;
			ei_q <= '0;
		end
	end

	sdap_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (I_CLOCK),
		.i_rstn      (I_RSTN),
		.i_in_valid  (f_push),
		.i_in_data   (f_data),
		.o_in_ready  (f_ready),
		.o_level     (f_level),
		.o_out_valid (O_BYTE_VALID),
		.o_out_data  (O_BYTE_DATA),
		.i_out_ready (I_BYTE_READY)
	);

	assign O_XFER_READY     = rdy_q;
	assign O_XFER_REJECT    = rej_q;
	assign O_ELEM_VALID     = ev_q;
	assign O_ELEM_ADDR      = ea_q;
	assign O_ELEM_BIG       = eb_q;
	assign O_ELEM_LEFT_KEY  = el_q;
	assign O_ELEM_RIGHT_KEY = rkey_q;
	assign O_ELEM_INDEX     = ei_q;
endmodule : short_data_address_packet_codec
`default_nettype wire

// ==== test/sdap_chk.sv ====
// Port checker for the short data address packet encoder
`timescale 1ns/1ps
`default_nettype none
module sdap_chk #(
	parameter int LKEY_W   = 8,
	parameter int RKEY_W   = 8,
	parameter int RKEY_MAX = 256,
	parameter int INDEX_W  = 4
) (
	input wire logic		I_CLOCK,
	input wire logic		I_RSTN,
	input wire logic		I_XFER_VALID,
	input wire logic [63:0]		I_XFER_ADDR,
	input wire logic		I_XFER_STEP2,
	input wire logic		O_XFER_READY,
	input wire logic		O_XFER_REJECT,
	input wire logic		I_ENDIAN_LOAD,
	input wire logic		I_ENDIAN_BIG,
	input wire logic		O_ELEM_VALID,
	input wire logic [63:0]		O_ELEM_ADDR,
	input wire logic		O_ELEM_BIG,
	input wire logic [LKEY_W-1:0]	O_ELEM_LEFT_KEY,
	input wire logic [RKEY_W-1:0]	O_ELEM_RIGHT_KEY,
	input wire logic [INDEX_W-1:0]	O_ELEM_INDEX
);
	logic	big_q;
	always_ff @(posedge I_CLOCK or negedge I_RSTN)
		if (!I_RSTN) big_q <= 1'b0;
		else if (I_ENDIAN_LOAD) big_q <= I_ENDIAN_BIG;
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RSTN);
	a_reply_next: assert property (
		I_XFER_VALID && O_XFER_READY |=> O_ELEM_VALID != O_XFER_REJECT)
		else $error("request without single reply");
	a_index_zero: assert property (
		O_ELEM_VALID |-> O_ELEM_INDEX == '0) else $error("index not zero");
	a_rkey_step: assert property (
		O_ELEM_VALID |-> O_ELEM_RIGHT_KEY ==
		RKEY_W'((int'($past(O_ELEM_RIGHT_KEY)) + 1) % RKEY_MAX))
		else $error("right key step wrong");
	a_lkey_step: assert property (
		O_ELEM_VALID |-> LKEY_W'(O_ELEM_LEFT_KEY - $past(O_ELEM_LEFT_KEY))
		== ($past(I_XFER_STEP2) ? 2 : 1)) else $error("left key step wrong");
	a_elem_addr: assert property (
		O_ELEM_VALID |-> O_ELEM_ADDR == $past(I_XFER_ADDR))
		else $error("element address wrong");
	a_elem_endian: assert property (
		O_ELEM_VALID |-> O_ELEM_BIG == $past(big_q))
		else $error("element endianness wrong");
	a_far_reject: assert property (
		I_XFER_VALID && O_XFER_READY && |I_XFER_ADDR[63:10]
		|=> O_XFER_REJECT) else $error("far address not rejected");
	a_word_accept: assert property (
		I_XFER_VALID && O_XFER_READY && !(|I_XFER_ADDR[63:10]) &&
		I_XFER_ADDR[1:0] == 2'h0 |=> O_ELEM_VALID) else $error("word refused");
endmodule : sdap_chk
bind short_data_address_packet_codec sdap_chk #(.LKEY_W(LKEY_W),
	.RKEY_W(RKEY_W), .RKEY_MAX(RKEY_MAX), .INDEX_W(INDEX_W)) i_sdap_chk (
	.I_CLOCK, .I_RSTN, .I_XFER_VALID, .I_XFER_ADDR, .I_XFER_STEP2,
	.O_XFER_READY, .O_XFER_REJECT, .I_ENDIAN_LOAD, .I_ENDIAN_BIG,
	.O_ELEM_VALID, .O_ELEM_ADDR, .O_ELEM_BIG, .O_ELEM_LEFT_KEY,
	.O_ELEM_RIGHT_KEY, .O_ELEM_INDEX);
`default_nettype wire

// ==== test/sdap_sink.sv ====
// Byte consumer standing in for the trace stream analyzer
`timescale 1ns/1ps
`default_nettype none
module sdap_sink (
	input  wire logic	i_clk,
	input  wire logic	i_rstn,
	input  wire logic	i_hold,
	output logic		o_ready
);
	// Random stalls, full stall while held
	always @(posedge i_clk or negedge i_rstn)
		if (!i_rstn) o_ready <= 1'b0;
		else o_ready <= !i_hold && ($urandom % 4 != 0);
endmodule : sdap_sink
`default_nettype wire

// ==== test/short_data_address_packet_codec_test.sv ====
// Self-checking bench for the short data address packet encoder
`timescale 1ns/1ps
`default_nettype none
module short_data_address_packet_codec_test;
	localparam int	RKM = 5;
	logic		clk = 0, rstn = 0, vld = 0, s2 = 0, ld = 0, big = 0;
	logic		hold = 0, rdy, rd, rej, bv, ev, eb, bm = 0;
	logic [7:0]	bd, lk_o, rk_o, lk = '0, rk = '0;
	logic [3:0]	ix;
	logic [63:0]	adr = '0, ea, h [3] = '{default: '0};
	logic [80:0]	last = '0;
	logic [81:0]	eq [$];
	logic [7:0]	bq [$];
	int		mismatches = 0, n_tests = 0;
	always #20 clk = ~clk;
	sdap_sink i_sdap_sink (.i_clk(clk), .i_rstn(rstn), .i_hold(hold),
		.o_ready(rdy));
	short_data_address_packet_codec #(.RKEY_MAX(RKM))
		i_short_data_address_packet_codec (.I_CLOCK(clk), .I_RSTN(rstn),
		.I_XFER_VALID(vld), .I_XFER_ADDR(adr), .I_XFER_STEP2(s2),
		.O_XFER_READY(rd), .O_XFER_REJECT(rej), .I_ENDIAN_LOAD(ld),
		.I_ENDIAN_BIG(big), .O_BYTE_VALID(bv), .O_BYTE_DATA(bd),
		.I_BYTE_READY(rdy), .O_ELEM_VALID(ev), .O_ELEM_ADDR(ea),
		.O_ELEM_BIG(eb), .O_ELEM_LEFT_KEY(lk_o), .O_ELEM_RIGHT_KEY(rk_o),
		.O_ELEM_INDEX(ix));
	task summarize;
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task hang;
		mismatches++;
		summarize;
	endtask : hang
	task chk(input logic [81:0] e, input logic [81:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task xfer(input logic [63:0] a, input logic t);
		logic [2:0]	m;
		logic [1:0]	sel;
		int		lo, f, n;
		logic		ok;
		f = (a[1:0] == 2'h2) ? 4 : 6;
		ok = 0;
		for (int k = 0; k < ((f == 4) ? 1 : 2); k++) if (!ok) begin
			lo = (k == 0) ? f : 10;
			for (int i = 0; i < 3; i++) m[i] = (h[i] >> lo) == (a >> lo);
			ok = t ? m[0] : |m;
			sel = t ? 2'h3 : (m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2));
		end
		ok = ok && !a[0];
		if (ok) begin
			h[(sel == 2'h3) ? 0 : sel] = a;
			lk += (sel == 2'h3) ? 8'h02 : 8'h01;
			rk = 8'((rk + 1) % RKM);
			last = {a, bm, lk, rk};
			if (lo == 4) bq.push_back({4'h6, a[3:2], sel});
			if (lo == 6) bq.push_back({2'h2, a[5:2], sel});
			if (lo == 10) bq.push_back({6'h05, sel});
			if (lo == 10) bq.push_back(a[9:2]);
		end
		eq.push_back({!ok, last});
		vld <= 1'b1;
		adr <= a;
		s2 <= t;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rd !== 1'b1 && n < 100);
		if (rd !== 1'b1) hang;
		@(posedge clk);
	endtask : xfer
	task endian(input logic b);
		@(posedge clk);
		ld <= 1'b1;
		big <= b;
		@(posedge clk);
		ld <= 1'b0;
		bm = b;
	endtask : endian
	always @(negedge clk) if (rstn) begin
		if ($isunknown({ev, rej, bv, rd})) begin
			mismatches++;
			$display("CHECK FAILED %0t unknown flag", $time);
		end
		if (ev || rej) begin
			if (eq.size() == 0) hang;
			chk(eq.pop_front(), {rej, ea, eb, lk_o, rk_o});
		end
		if (ev) chk(82'h0, 82'(ix));
		if (bv && rdy) begin
			if (bq.size() == 0) hang;
			chk(82'(bq.pop_front()), 82'(bd));
		end
	end
	initial begin
		void'($urandom(32'ha0d9));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		xfer(64'h24, 0);
		xfer(64'h3fc, 0);
		xfer(64'h40, 0);
		xfer(64'h80, 0);
		xfer(64'h8a, 1);
		xfer(64'h0e, 0);
		xfer(64'h44, 1);
		xfer(64'h3c, 0);
		xfer(64'h0a, 0);
		xfer(64'h1_0000, 0);
		xfer(64'h3, 0);
		xfer(64'h86, 1);
		vld <= 1'b0;
		hold <= 1'b1;
		fork
			begin
				repeat (60) @(posedge clk);
				hold <= 1'b0;
			end
		join_none
		for (int j = 0; j < 2; j++) begin
			endian(j == 0);
			for (int i = 0; i < 30; i++)
				xfer({$urandom, $urandom} & 64'h7ff, $urandom % 4 == 0);
			vld <= 1'b0;
		end
		for (int n = 0; n < 500 && eq.size() + bq.size() > 0; n++)
			@(negedge clk);
		if (eq.size() + bq.size() > 0) hang;
		summarize;
	end
endmodule : short_data_address_packet_codec_test
`default_nettype wire
